// ==== dv/fls_flash_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fls_flash_model
  import fls_pkg::*;
(
  input  wire logic            clk,
  input  wire logic [FA_W-1:0] addr,
  input  wire logic [DQ_W-1:0] dq_in,
  input  wire logic            ce_n,
  input  wire logic            we_n,
  input  wire logic            oe_n,
  input  wire logic            rp_n,
  input  wire logic [2:0]      fault,
  input  wire logic [7:0]      busy_len,
  output logic      [DQ_W-1:0] dq_out,
  output logic                 rb_oe_n
);
  // ----------------------------------------------------------------
  // Device state
  // ----------------------------------------------------------------
  // Fault codes: 1 operation fails, 2 supply error, 3 permanent lock set, 4 bad sequence
  logic [7:0] mem [256];
  logic [7:0] sr;
  logic [7:0] err;
  logic [7:0] cnt;
  logic [7:0] last;
  logic [7:0] rd;
  logic [1:0] pend;
  logic       busy;
  logic       stat_mode;
  logic       we_q;

  initial begin
    last = 8'h00;
    for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  end

  function automatic logic [7:0] outcome(input logic [1:0] p, input logic [7:0] d);
    logic [7:0] fb;
    fb = (p == 2'h1 && d == CMD_CLEAR_CONFIRM) ? 8'h20 : 8'h10;
    if (fault == 3'h4 || (p == 2'h1 && !(d inside {CMD_BLOCK_CONFIRM, CMD_PERM_CONFIRM, CMD_CLEAR_CONFIRM})))
      return 8'h30;
    if (fault == 3'h3 && p == 2'h1 && d != CMD_PERM_CONFIRM) return fb | 8'h02;
    if (fault == 3'h2) return fb | 8'h08;
    if (fault == 3'h1) return fb;
    return 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Command latch and internal algorithm
  // ----------------------------------------------------------------
  // Commands are taken on the rising write strobe; no command is taken while busy
  always @(posedge clk or negedge rp_n) begin
    if (!rp_n) begin
      sr <= 8'h00;
      busy <= 1'b0;
      stat_mode <= 1'b0;
      pend <= 2'h0;
      we_q <= 1'b1;
    end else begin
      we_q <= we_n;
      if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        sr <= sr | err;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
      if (we_n && !we_q && !ce_n && !busy) begin
        stat_mode <= 1'b1;
        pend <= 2'h0;
        if (pend != 2'h0) begin
          busy <= 1'b1;
          cnt <= busy_len;
          err <= outcome(pend, dq_in);
          if (pend == 2'h2 && outcome(pend, dq_in) == 8'h00) mem[addr[7:0]] <= dq_in;
        end else begin
          case (dq_in)
            CMD_READ_ARRAY:   stat_mode <= 1'b0;
            CMD_CLEAR_STATUS: sr <= 8'h00;
            CMD_LOCK_SETUP:   pend <= 2'h1;
            CMD_OTP_SETUP:    pend <= 2'h2;
            default: ;
          endcase
        end
      end
    end
  end

  assign rd = stat_mode ? {!busy, sr[6:0]} : mem[addr[7:0]];
  always @(posedge clk) if (!ce_n && !oe_n) last <= rd;
  // A released bus must not look like a stale but valid byte
  assign dq_out = (!ce_n && !oe_n && rp_n) ? rd : ~last;
  assign rb_oe_n = !(busy && rp_n);
endmodule
`default_nettype wire

// ==== dv/fls_host_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module fls_host_bench
  import fls_pkg::*;
;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata;
  logic            pready, pslverr, irq, e, low;
  logic [FA_W-1:0] faddr;
  logic [DQ_W-1:0] fdq_out, fdq_in;
  logic            dq_oe_n, ce_n, we_n, oe_n, rp_n, rb_oe_n, rb;
  logic [2:0]      fault = 3'h0;
  logic [7:0]      busy_len = 8'h04;
  logic [7:0]      dv;
  logic [19:0]     a;
  logic [31:0]     r, mask;
  int              bad_count = 0, checks_done = 0, seed = 83492, op;
  int              kinds [8] = '{3, 1, 2, 0, 4, 0, 3, 1};

  always #12.5 pclk = ~pclk;
  // Pull-up on the open-drain ready line
  assign rb = rb_oe_n ? 1'b1 : 1'b0;

  fls_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .flash_addr(faddr), .flash_dq_out(fdq_out), .flash_dq_in(fdq_in), .flash_dq_oe_n(dq_oe_n),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_rp_n(rp_n), .ready_busy_out(rb));

  fls_flash_model u_dev (.clk(pclk), .addr(faddr), .dq_in(fdq_out), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .rp_n(rp_n), .fault(fault), .busy_len(busy_len), .dq_out(fdq_in), .rb_oe_n(rb_oe_n));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("bus answer timed out");
      stop_test();
    end
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, ad, d, q, er);
  endtask

  // Starts an operation and polls until the sequencer is idle; notes a low ready line while busy
  task automatic run_op(input int o, output logic saw_low);
    int n;
    wr(REG_CTRL, 32'(o));
    saw_low = 1'b0;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      if (r[ST_BUSY_BIT] === 1'b1 && r[ST_RB_BIT] === 1'b0) saw_low = 1'b1;
      n++;
    end while (r[ST_BUSY_BIT] !== 1'b0 && n < 500);
    if (r[ST_BUSY_BIT] !== 1'b0) begin
      bad_count++;
      $display("operation never finished");
      stop_test();
    end
  endtask

  function automatic logic [7:0] exp_sts(input int o, input int f);
    logic [7:0] fb;
    fb = (o == 3) ? 8'h20 : 8'h10;
    case (f)
      1: return 8'h80 | fb;
      2: return 8'h88 | fb;
      3: return (o == 1 || o == 3) ? (8'h82 | fb) : 8'h80;
      4: return 8'hB0;
      default: return 8'h80;
    endcase
  endfunction

  initial begin
    int k;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    check("status after reset", r & 32'h0000_0700, 32'h0000_0600);
    check("device reset pin", 32'(rp_n), 32'h0);
    wr(REG_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    check("device reset pin", 32'(rp_n), 32'h1);
    check("device mode", 32'(u_dev.stat_mode), 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    check("unmapped read", {r[30:0], e}, 32'h1);
    $display("test reset and map done");
    for (int i = 0; i < 16; i++) begin
      op = i % 4 + 1;
      k = (i < 8) ? kinds[i] : int'($unsigned($random(seed)) % 5);
      fault <= 3'(k);
      busy_len <= (i % 3 == 0) ? 8'h28 : 8'($unsigned($random(seed)) % 8);
      mask = (i % 2 == 1) ? 32'h3 : 32'h0;
      a = 20'($random(seed));
      dv = 8'($random(seed));
      wr(REG_ADDR, {12'h0, a});
      wr(REG_DATA, {24'h0, dv});
      wr(REG_IRQ_MASK, mask);
      apb(1'b0, REG_ADDR, 32'h0, r, e);
      check("addr readback", r, {12'h0, a});
      run_op(op, low);
      apb(1'b0, REG_CTRL, 32'h0, r, e);
      check("ctrl readback", r, 32'(op));
      apb(1'b0, REG_STATUS, 32'h0, r, e);
      check("device status", {24'h0, r[7:0]}, {24'h0, exp_sts(op, k)});
      check("device errors left", {24'h0, u_dev.sr}, 32'h0);
      check("device mode", 32'(u_dev.stat_mode), 32'h0);
      if (busy_len == 8'h28) check("ready line low", 32'(low), 32'h1);
      apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
      check("irq status", r, {30'h0, exp_sts(op, k) != 8'h80, 1'b1});
      check("irq line", 32'(irq), 32'(mask != 32'h0));
      wr(REG_IRQ_STAT, 32'h3);
      apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
      check("irq cleared", r, 32'h0);
      if (op == 4 && k == 0) begin
        run_op(5, low);
        apb(1'b0, REG_DATA, 32'h0, r, e);
        check("otp byte", r, {24'h0, dv});
      end
      $display("test operation %0d fault %0d done", op, k);
    end
    wr(REG_IRQ_STAT, 32'h3);
    run_op(6, low);
    check("clear status mode", 32'(u_dev.stat_mode), 32'h0);
    check("clear status errors", {24'h0, u_dev.sr}, 32'h0);
    apb(1'b0, REG_IRQ_STAT, 32'h0, r, e);
    check("clear status done", r, 32'h1);
    $display("test clear status done");
    wr(REG_CTRL, 32'h100);
    repeat (2) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    check("held in reset", r & 32'h0000_0600, 32'h0000_0600);
    $display("test reset hold done");
    stop_test();
  end
endmodule
`default_nettype wire

// ==== src/fls_cycle.sv ====
`timescale 1ns/100ps
`default_nettype none
module fls_cycle
  import fls_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            start,
  input  wire logic            wr,
  input  wire logic [FA_W-1:0] addr,
  input  wire logic [DQ_W-1:0] wdata,
  output logic                 done,
  output logic      [DQ_W-1:0] rdata,
  output logic      [FA_W-1:0] flash_addr,
  output logic      [DQ_W-1:0] flash_dq_out,
  input  wire logic [DQ_W-1:0] flash_dq_in,
  output logic                 flash_dq_oe_n,
  output logic                 flash_ce_n,
  output logic                 flash_we_n,
  output logic                 flash_oe_n
);

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fls_eng_t;

  fls_eng_t         state;
  logic             is_wr;
  logic [CNT_W-1:0] cnt;

  // ----------------------------------------------------------------
  // One bus cycle: address setup, strobe, hold with strobe released
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= E_IDLE;
      is_wr         <= 1'b0;
      cnt           <= '0;
      done          <= 1'b0;
      rdata         <= '0;
      flash_addr    <= '0;
      flash_dq_out  <= '0;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
    end else begin
      done <= 1'b0;
      unique case (state)
        E_IDLE: begin
          if (start) begin
            is_wr         <= wr;
            flash_addr    <= addr;
            flash_dq_out  <= wdata;
            flash_dq_oe_n <= ~wr;
            flash_ce_n    <= 1'b0;
            state         <= E_SETUP;
          end
        end
        E_SETUP: begin
          flash_we_n <= ~is_wr;
          flash_oe_n <= is_wr;
          cnt        <= is_wr ? CNT_W'(WE_PULSE_CYC - 1) : CNT_W'(OE_ACCESS_CYC - 1);
          state      <= E_STROBE;
        end
        E_STROBE: begin
          if (cnt == '0) begin
            // Data is latched by the device on the rising write strobe
            if (!is_wr) begin
              rdata <= flash_dq_in;
            end
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            state      <= E_HOLD;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        E_HOLD: begin
          flash_ce_n    <= 1'b1;
          flash_dq_oe_n <= 1'b1;
          done          <= 1'b1;
          state         <= E_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== src/fls_host.sv ====
// Summary of operation
// - After the last lock-bit set the controller writes the read-array command so reads return array data again.
// - Clearing all block locks is a 60H setup write then a D0H confirm write, followed by status polling.
// - OTP programming is a C0H setup write then a data write at the target, followed by status polling.
// - On any error flag the controller issues clear-status before anything else.
`timescale 1ns/100ps
`default_nettype none
module fls_host
  import fls_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic                 irq,
  output logic      [FA_W-1:0] flash_addr,
  output logic      [DQ_W-1:0] flash_dq_out,
  input  wire logic [DQ_W-1:0] flash_dq_in,
  output logic                 flash_dq_oe_n,
  output logic                 flash_ce_n,
  output logic                 flash_we_n,
  output logic                 flash_oe_n,
  output logic                 flash_rp_n,
  input  wire logic            ready_busy_out
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_CONFIRM, ST_POLL_CMD, ST_POLL_READ, ST_CLEAR, ST_ARRAY, ST_READ_DATA
  } fls_state_t;

  function automatic logic fls_mapped(input logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_DATA) ||
           (a == REG_STATUS) || (a == REG_IRQ_STAT) || (a == REG_IRQ_MASK);
  endfunction

  fls_state_t       state;
  logic [2:0]       op;
  logic             issued;
  logic             rp_hold;
  logic [FA_W-1:0]  addr_reg;
  logic [DQ_W-1:0]  data_reg;
  logic [DQ_W-1:0]  read_data;
  logic [DQ_W-1:0]  dev_status;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic             eng_start;
  logic             eng_wr;
  logic [FA_W-1:0]  eng_addr;
  logic [DQ_W-1:0]  eng_data;
  logic             eng_done;
  logic [DQ_W-1:0]  eng_rdata;
  logic             next_wr;
  logic [FA_W-1:0]  next_addr;
  logic [DQ_W-1:0]  next_data;
  logic             acc;
  logic             wr_fire;
  logic             go;
  logic             seq_busy;
  logic             sts_err;

  assign acc      = psel & penable;
  assign wr_fire  = acc & pready & pwrite;
  assign seq_busy = (state != ST_IDLE);
  assign sts_err  = |(eng_rdata & STS_ERR_MASK);
  assign go       = wr_fire && (paddr == REG_CTRL) && !seq_busy && !pwdata[CTRL_RP_BIT] && !rp_hold &&
                    (pwdata[2:0] != OP_NONE) && (pwdata[2:0] <= OP_CLEAR_STATUS);

  // ----------------------------------------------------------------
  // APB slave: one wait state, registered answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~fls_mapped(paddr);
      prdata  <= '0;
      if (acc && !pready && !pwrite) begin
        unique case (paddr)
          REG_CTRL:     prdata <= {23'h000000, rp_hold, 5'h00, op};
          REG_ADDR:     prdata <= {12'h000, addr_reg};
          REG_DATA:     prdata <= {24'h000000, read_data};
          // Ready/busy is sampled with no regard to the strobes
          REG_STATUS:   prdata <= {21'h000000, rp_hold, ready_busy_out, seq_busy, dev_status};
          REG_IRQ_STAT: prdata <= {30'h00000000, irq_stat};
          REG_IRQ_MASK: prdata <= {30'h00000000, irq_mask};
          default:      prdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= '0;
      data_reg <= '0;
      irq_mask <= '0;
    end else if (wr_fire) begin
      if (paddr == REG_ADDR) begin
        addr_reg <= pwdata[FA_W-1:0];
      end
      if (paddr == REG_DATA) begin
        data_reg <= pwdata[DQ_W-1:0];
      end
      if (paddr == REG_IRQ_MASK) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Device reset pin: held low in our reset and on software request
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_hold    <= 1'b1;
      flash_rp_n <= 1'b0;
    end else begin
      if (wr_fire && paddr == REG_CTRL && !seq_busy) begin
        rp_hold <= pwdata[CTRL_RP_BIT];
      end
      // Leaving reset puts the device in read-array mode with status cleared
      flash_rp_n <= ~rp_hold;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: set beats a write-one-to-clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_fire && paddr == REG_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0)) | irq_set;
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Next bus cycle for each step
  // ----------------------------------------------------------------
  always_comb begin
    next_wr   = 1'b1;
    next_addr = '0;
    next_data = CMD_READ_ARRAY;
    unique case (state)
      ST_IDLE:      next_data = CMD_READ_ARRAY;
      ST_SETUP:     next_data = (op == OP_OTP) ? CMD_OTP_SETUP : CMD_LOCK_SETUP;
      ST_CONFIRM: begin
        next_addr = addr_reg;
        unique case (op)
          OP_SET_BLOCK:   next_data = CMD_BLOCK_CONFIRM;
          OP_SET_PERM:    next_data = CMD_PERM_CONFIRM;
          OP_CLEAR_LOCKS: next_data = CMD_CLEAR_CONFIRM;
          default:        next_data = data_reg;
        endcase
      end
      ST_POLL_CMD:  next_data = CMD_READ_STATUS;
      ST_POLL_READ: next_wr   = 1'b0;
      ST_CLEAR:     next_data = CMD_CLEAR_STATUS;
      ST_ARRAY:     next_data = CMD_READ_ARRAY;
      ST_READ_DATA: begin
        next_wr   = 1'b0;
        next_addr = addr_reg;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      op         <= OP_NONE;
      issued     <= 1'b0;
      eng_start  <= 1'b0;
      eng_wr     <= 1'b0;
      eng_addr   <= '0;
      eng_data   <= '0;
      dev_status <= '0;
      read_data  <= '0;
      irq_set    <= '0;
    end else begin
      eng_start <= 1'b0;
      irq_set   <= '0;
      if (state == ST_IDLE) begin
        issued <= 1'b0;
        if (go) begin
          op <= pwdata[2:0];
          unique case (pwdata[2:0])
            OP_READ:         state <= ST_ARRAY;
            OP_CLEAR_STATUS: state <= ST_CLEAR;
            default:         state <= ST_SETUP;
          endcase
        end
      end else if (!issued) begin
        eng_start <= 1'b1;
        eng_wr    <= next_wr;
        eng_addr  <= next_addr;
        eng_data  <= next_data;
        issued    <= 1'b1;
      end else if (eng_done) begin
        issued <= 1'b0;
        unique case (state)
          ST_SETUP:    state <= ST_CONFIRM;
          ST_CONFIRM:  state <= ST_POLL_CMD;
          ST_POLL_CMD: state <= ST_POLL_READ;
          ST_POLL_READ: begin
            // Status reads repeat without a new 70H until the device reports ready
            if (eng_rdata[STS_READY_BIT]) begin
              dev_status <= eng_rdata;
              // Sticky device errors (bits 5,4,3,1) are cleared before the next operation
              if (sts_err) begin
                irq_set[IRQ_ERR] <= 1'b1;
                state            <= ST_CLEAR;
              end else begin
                state <= ST_ARRAY;
              end
            end
          end
          ST_CLEAR:    state <= ST_ARRAY;
          ST_ARRAY: begin
            // Read-array restored after every operation
            if (op == OP_READ) begin
              state <= ST_READ_DATA;
            end else begin
              irq_set[IRQ_DONE] <= 1'b1;
              state             <= ST_IDLE;
            end
          end
          ST_READ_DATA: begin
            read_data         <= eng_rdata;
            irq_set[IRQ_DONE] <= 1'b1;
            state             <= ST_IDLE;
          end
          default:     state <= ST_IDLE;
        endcase
      end
    end
  end

  fls_cycle u_cycle (
    .pclk          (pclk),
    .presetn       (presetn),
    .start         (eng_start),
    .wr            (eng_wr),
    .addr          (eng_addr),
    .wdata         (eng_data),
    .done          (eng_done),
    .rdata         (eng_rdata),
    .flash_addr    (flash_addr),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_in   (flash_dq_in),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_ce_n    (flash_ce_n),
    .flash_we_n    (flash_we_n),
    .flash_oe_n    (flash_oe_n)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [DQ_W-1:0] last_written;
  logic            clr_sent;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_written <= '0;
      clr_sent     <= 1'b0;
    end else begin
      if (!flash_we_n) begin
        last_written <= flash_dq_out;
      end
      if (go) begin
        clr_sent <= 1'b0;
      end else if (!flash_we_n && flash_dq_out == CMD_CLEAR_STATUS) begin
        clr_sent <= 1'b1;
      end
    end
  end

  a_array_at_end: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(seq_busy) && op != OP_READ |-> last_written == CMD_READ_ARRAY)
    else $error("operation ended without read-array command");

  a_clear_confirm_pair: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(flash_we_n) && op == OP_CLEAR_LOCKS && flash_dq_out == CMD_CLEAR_CONFIRM |-> last_written == CMD_LOCK_SETUP)
    else $error("lock clear confirm without setup");

  a_otp_setup_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == ST_CONFIRM) && op == OP_OTP |-> last_written == CMD_OTP_SETUP)
    else $error("OTP data write without setup");

  a_clear_on_error: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(seq_busy) && |(dev_status & STS_ERR_MASK) && op != OP_READ && op != OP_CLEAR_STATUS |-> clr_sent)
    else $error("error left uncleared");

  a_poll_until_ready: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_POLL_READ && issued && eng_done && !eng_rdata[STS_READY_BIT] |=> state == ST_POLL_READ)
    else $error("left polling while device busy");

  a_status_cmd_first: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_POLL_READ && eng_start |-> last_written == CMD_READ_STATUS)
    else $error("status read without status command");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    irq_set[IRQ_DONE] && irq_mask[IRQ_DONE] && !wr_fire |=> ##1 irq)
    else $error("done interrupt not raised");

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

endmodule
`default_nettype wire

// ==== src/fls_pkg.sv ====
package fls_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int WE_PULSE_NS   = 60;
  localparam int OE_ACCESS_NS  = 90;
  localparam int WE_PULSE_CYC  = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_ACCESS_CYC = (OE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;

  // ----------------------------------------------------------------
  // Flash pins
  // ----------------------------------------------------------------
  localparam int FA_W = 20;
  localparam int DQ_W = 8;

  // ----------------------------------------------------------------
  // Device commands and status bits
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_LOCK_SETUP    = 8'h60;
  localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_PERM_CONFIRM  = 8'hF1;
  localparam logic [7:0] CMD_CLEAR_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_OTP_SETUP     = 8'hC0;
  localparam int         STS_READY_BIT     = 7;
  localparam logic [7:0] STS_ERR_MASK      = 8'h3A;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_DATA     = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam int         CTRL_RP_BIT  = 8;
  localparam int         ST_BUSY_BIT  = 8;
  localparam int         ST_RB_BIT    = 9;
  localparam int         ST_RP_BIT    = 10;
  localparam int         IRQ_DONE     = 0;
  localparam int         IRQ_ERR      = 1;
  localparam int         IRQ_W        = 2;

  // Operation codes written to the control register
  localparam logic [2:0] OP_NONE         = 3'h0;
  localparam logic [2:0] OP_SET_BLOCK    = 3'h1;
  localparam logic [2:0] OP_SET_PERM     = 3'h2;
  localparam logic [2:0] OP_CLEAR_LOCKS  = 3'h3;
  localparam logic [2:0] OP_OTP          = 3'h4;
  localparam logic [2:0] OP_READ         = 3'h5;
  localparam logic [2:0] OP_CLEAR_STATUS = 3'h6;

endpackage
